/* File: src/ats_pkg.sv */
// constants and types shared by the acquisition trigger sequencer files
// assumes one 40 MHz system clock and a word-aligned register port

// ============================================================
// package
package ats_pkg;

    // register port widths
    localparam int ATS_AW = 8;
    localparam int ATS_DW = 32;

    // ============================================================
    // register byte addresses
    localparam logic [ATS_AW-1:0] ATS_ADDR_CTRL    = 8'h00;
    localparam logic [ATS_AW-1:0] ATS_ADDR_FCOUNT  = 8'h04;
    localparam logic [ATS_AW-1:0] ATS_ADDR_PERIOD  = 8'h08;
    localparam logic [ATS_AW-1:0] ATS_ADDR_CMD     = 8'h0C;
    localparam logic [ATS_AW-1:0] ATS_ADDR_STATUS  = 8'h10;
    localparam logic [ATS_AW-1:0] ATS_ADDR_TOTAL   = 8'h14;
    localparam logic [ATS_AW-1:0] ATS_ADDR_IGNORED = 8'h18;

    // ============================================================
    // control register fields
    localparam int ATS_CTRL_W        = 6;
    localparam int ATS_CTRL_ACQ_EN   = 0;  // acquisition start trigger mode on
    localparam int ATS_CTRL_FRM_EN   = 1;  // frame start trigger mode on (line 1)
    localparam int ATS_CTRL_ACT_FALL = 2;  // 0 rising edge, 1 falling edge
    localparam int ATS_CTRL_DIR_OUT  = 3;  // 0 line is input, 1 line is output
    localparam int ATS_CTRL_LINE_VAL = 4;  // level driven when line is output
    localparam int ATS_CTRL_RATE_EN  = 5;  // programmed frame period in use
    localparam logic [ATS_CTRL_W-1:0] ATS_CTRL_RST = 6'h00;

    // command register bits, write-only pulses
    localparam int ATS_CMD_START = 0;
    localparam int ATS_CMD_STOP  = 1;
    localparam int ATS_CMD_TRIG  = 2;

    // status register fields
    localparam int ATS_STAT_STATE_LSB = 0;
    localparam int ATS_STAT_LINE      = 3;
    localparam int ATS_STAT_BURST_LSB = 16;

    // ============================================================
    // counter widths and reset values
    localparam int ATS_FCOUNT_W = 16;
    localparam int ATS_PERIOD_W = 24;
    localparam int ATS_TOTAL_W  = 32;
    localparam int ATS_IGN_W    = 16;
    localparam logic [ATS_FCOUNT_W-1:0] ATS_FCOUNT_RST = 16'h0001;
    localparam logic [ATS_PERIOD_W-1:0] ATS_PERIOD_RST = 24'h000FA0;

    // ============================================================
    // timing: shortest frame period allowed, a least time so rounded up
    localparam int ATS_CLK_PERIOD_NS = 25;
    localparam int ATS_MIN_FRAME_NS  = 1000;
    localparam logic [ATS_PERIOD_W-1:0] ATS_MIN_FRAME_CYC =
        ATS_PERIOD_W'((ATS_MIN_FRAME_NS + ATS_CLK_PERIOD_NS - 1) / ATS_CLK_PERIOD_NS);

    // acquisition status, one-hot
    typedef enum logic [2:0] {
        ATS_ST_IDLE       = 3'b001,
        ATS_ST_WAIT_ACQ   = 3'b010,
        ATS_ST_WAIT_FRAME = 3'b100
    } ats_state_t;

endpackage

/* File: src/ats_edge_sync.sv */
// three-stage pin synchroniser with a filtered level and edge pulses
// assumes the pin is asynchronous to sys_clk; pulses are one cycle wide

`timescale 1ns/1ps

// ============================================================
// synchroniser and edge detector
module ats_edge_sync
(
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic pin_in,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    import ats_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level_r;
        logic rise_r;
        logic fall_r;
    } ats_sync_t;

    localparam ats_sync_t SYNC_RST = '{default: 1'b0};

    ats_sync_t q;
    ats_sync_t n;

    // a change counts only once stages two and three agree; s1 feeds s2 only
    always_comb
    begin
        n        = q;
        n.s1     = pin_in;
        n.s2     = q.s1;
        n.s3     = q.s2;
        n.rise_r = 1'b0;
        n.fall_r = 1'b0;
        if ((q.s2 == q.s3) && (q.s3 != q.level_r))
        begin
            n.level_r = q.s3;
            n.rise_r  = q.s3;
            n.fall_r  = !q.s3;
        end
    end

    // state register, frozen while ce is low
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            q <= SYNC_RST;
        else if (ce)
            q <= n;
    end

    assign level = q.level_r;
    assign rise  = q.rise_r;
    assign fall  = q.fall_r;

    // ============================================================
    // checks
    a_rise_level : assert property (@(posedge sys_clk) disable iff (!rst_n)
        rise |-> level && !fall)
        else $error("rise pulse without high level");

endmodule

/* File: src/ats_sequencer.sv */
// acquisition trigger sequencer: acquisition and frame start control
// assumes a single-cycle register port master on sys_clk and an
// asynchronous trigger source on line 1
//
// Design decisions made here: the plain strobed port and the placing of the registers.

`timescale 1ns/1ps

// ============================================================
// top module
module ats_sequencer
(
    input  wire logic                     sys_clk,
    input  wire logic                     rst_n,
    input  wire logic                     ce,
    input  wire logic [ats_pkg::ATS_AW-1:0] reg_addr,
    input  wire logic [ats_pkg::ATS_DW-1:0] reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [ats_pkg::ATS_DW-1:0] reg_rdata,
    input  wire logic                     line1_in,
    output logic                          line1_out,
    output logic                          line1_oe,
    output logic                          frame_start,
    output logic                          waiting_acq,
    output logic                          waiting_frame
);
    import ats_pkg::*;

    // ============================================================
    // state
    typedef struct packed {
        ats_state_t              state;
        logic [ATS_CTRL_W-1:0]   ctrl;
        logic [ATS_FCOUNT_W-1:0] fcount;
        logic [ATS_PERIOD_W-1:0] period;
        logic [ATS_FCOUNT_W-1:0] burst;
        logic [ATS_PERIOD_W-1:0] tick;
        logic [ATS_TOTAL_W-1:0]  total;
        logic [ATS_IGN_W-1:0]    ignored;
        logic [ATS_DW-1:0]       rd_data;
        logic                    frame_start;
    } ats_core_t;

    localparam ats_core_t CORE_RST = '{
        state:       ATS_ST_IDLE,
        ctrl:        ATS_CTRL_RST,
        fcount:      ATS_FCOUNT_RST,
        period:      ATS_PERIOD_RST,
        burst:       '0,
        tick:        '0,
        total:       '0,
        ignored:     '0,
        rd_data:     '0,
        frame_start: 1'b0
    };

    ats_core_t q;
    ats_core_t n;

    logic                    line_level;
    logic                    line_rise;
    logic                    line_fall;
    logic                    wr_ctrl;
    logic                    wr_fcount;
    logic                    wr_period;
    logic                    wr_cmd;
    logic                    wr_ign;
    logic                    cmd_start;
    logic                    cmd_stop;
    logic                    cmd_trig;
    logic                    line_is_input;
    logic                    line_edge;
    logic                    acq_trig;
    logic                    int_tick;
    logic                    frame_trig;
    logic [ATS_PERIOD_W-1:0] period_eff;
    logic [ATS_FCOUNT_W-1:0] burst_nxt;

    // ============================================================
    // line 1 synchroniser
    ats_edge_sync u_line_sync
    (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .ce      (ce),
        .pin_in  (line1_in),
        .level   (line_level),
        .rise    (line_rise),
        .fall    (line_fall)
    );

    // ============================================================
    // register port decode
    assign wr_ctrl   = reg_wr && (reg_addr == ATS_ADDR_CTRL);
    assign wr_fcount = reg_wr && (reg_addr == ATS_ADDR_FCOUNT);
    assign wr_period = reg_wr && (reg_addr == ATS_ADDR_PERIOD);
    assign wr_cmd    = reg_wr && (reg_addr == ATS_ADDR_CMD);
    assign wr_ign    = reg_wr && (reg_addr == ATS_ADDR_IGNORED);
    assign cmd_start = wr_cmd && reg_wdata[ATS_CMD_START];
    assign cmd_stop  = wr_cmd && reg_wdata[ATS_CMD_STOP];
    assign cmd_trig  = wr_cmd && reg_wdata[ATS_CMD_TRIG];

    // ============================================================
    // trigger sources
    // an output line would see its own drive, so only an input line triggers
    assign line_is_input = !q.ctrl[ATS_CTRL_DIR_OUT];
    assign line_edge     = line_is_input &&
                           (q.ctrl[ATS_CTRL_ACT_FALL] ? line_fall : line_rise);

    // acquisition start: software command, or always present when mode is off
    assign acq_trig = q.ctrl[ATS_CTRL_ACQ_EN] ? cmd_trig : 1'b1;

    // internal frame rate; a short programmed period is clamped to the maximum rate
    always_comb
    begin
        period_eff = ATS_MIN_FRAME_CYC;
        if (q.ctrl[ATS_CTRL_RATE_EN] && (q.period > ATS_MIN_FRAME_CYC))
            period_eff = q.period;
    end

    // >= rather than == so that shortening the period never skips a tick
    assign int_tick   = (q.tick >= (period_eff - ATS_PERIOD_W'(1)));
    assign frame_trig = q.ctrl[ATS_CTRL_FRM_EN] ? line_edge : int_tick;
    assign burst_nxt  = q.burst + ATS_FCOUNT_W'(1);

    // ============================================================
    // next state: sequencer, counters and registers
    always_comb
    begin
        n             = q;
        n.frame_start = 1'b0;
        n.rd_data     = '0;

        // frame period timer runs only while frames are awaited
        if (q.state == ATS_ST_WAIT_FRAME)
            n.tick = int_tick ? '0 : q.tick + ATS_PERIOD_W'(1);
        else
            n.tick = '0;

        unique case (q.state)
            ATS_ST_IDLE:
            begin
                if (cmd_start)
                begin
                    n.state = ATS_ST_WAIT_ACQ;
                    n.burst = '0;
                end
            end
            ATS_ST_WAIT_ACQ:
            begin
                // no frame leaves this state until a start trigger arrives
                if (cmd_stop)
                    n.state = ATS_ST_IDLE;
                else if (acq_trig)
                begin
                    n.state = ATS_ST_WAIT_FRAME;
                    n.burst = '0;
                end
            end
            ATS_ST_WAIT_FRAME:
            begin
                if (cmd_stop)
                    n.state = ATS_ST_IDLE;
                else if (frame_trig)
                begin
                    n.frame_start = 1'b1;
                    n.total       = q.total + ATS_TOTAL_W'(1);
                    n.burst       = burst_nxt;
                    // a count of zero behaves as one
                    if (burst_nxt >= q.fcount)
                        n.state = ATS_ST_WAIT_ACQ;
                end
            end
            default:
            begin
                n.state = ATS_ST_IDLE;
            end
        endcase

        // discarded edges are counted; a clear in the same cycle takes effect and the event then counts as one
        if (q.ctrl[ATS_CTRL_FRM_EN] && line_edge && (q.state != ATS_ST_WAIT_FRAME))
            n.ignored = wr_ign ? ATS_IGN_W'(1) : q.ignored + ATS_IGN_W'(1);
        else if (wr_ign)
            n.ignored = '0;

        // configuration writes
        if (wr_ctrl)
            n.ctrl = reg_wdata[ATS_CTRL_W-1:0];
        if (wr_fcount)
            n.fcount = reg_wdata[ATS_FCOUNT_W-1:0];
        if (wr_period)
            n.period = reg_wdata[ATS_PERIOD_W-1:0];

        // read data stands one cycle after the strobe; unmapped reads give zero
        if (reg_rd)
        begin
            unique case (reg_addr)
                ATS_ADDR_CTRL:    n.rd_data[ATS_CTRL_W-1:0]   = q.ctrl;
                ATS_ADDR_FCOUNT:  n.rd_data[ATS_FCOUNT_W-1:0] = q.fcount;
                ATS_ADDR_PERIOD:  n.rd_data[ATS_PERIOD_W-1:0] = q.period;
                ATS_ADDR_STATUS:
                begin
                    n.rd_data[ATS_STAT_STATE_LSB +: $bits(ats_state_t)] = q.state;
                    n.rd_data[ATS_STAT_LINE]                      = line_level;
                    n.rd_data[ATS_STAT_BURST_LSB +: ATS_FCOUNT_W] = q.burst;
                end
                ATS_ADDR_TOTAL:   n.rd_data                   = q.total;
                ATS_ADDR_IGNORED: n.rd_data[ATS_IGN_W-1:0]    = q.ignored;
                default:          n.rd_data                   = '0;
            endcase
        end
    end

    // state register, frozen while ce is low
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            q <= CORE_RST;
        else if (ce)
            q <= n;
    end

    // ============================================================
    // outputs
    assign reg_rdata     = q.rd_data;
    assign frame_start   = q.frame_start;
    assign waiting_acq   = (q.state == ATS_ST_WAIT_ACQ);
    assign waiting_frame = (q.state == ATS_ST_WAIT_FRAME);
    assign line1_oe      = q.ctrl[ATS_CTRL_DIR_OUT];   // driven only as an output
    assign line1_out     = q.ctrl[ATS_CTRL_LINE_VAL];

    // ============================================================
    // checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    a_acq_wait_hold : assert property (
        ce && waiting_acq && q.ctrl[ATS_CTRL_ACQ_EN] && !cmd_trig
        |=> !frame_start [*2])
        else $error("frame started while waiting for acquisition start");

    a_sw_trig_enter : assert property (
        ce && waiting_acq && q.ctrl[ATS_CTRL_ACQ_EN] && cmd_trig && !cmd_stop
        |=> waiting_frame && (q.burst == '0))
        else $error("software trigger did not open frame wait");

    a_burst_end : assert property (
        ce && waiting_frame && frame_trig && !cmd_stop && (burst_nxt >= q.fcount)
        |=> waiting_acq && frame_start)
        else $error("burst did not end at frame count");

    a_rearm_needed : assert property (
        ce && waiting_acq && q.ctrl[ATS_CTRL_ACQ_EN] && !cmd_trig && !cmd_stop
        |=> waiting_acq)
        else $error("left acquisition wait without command");

    a_edge_frame : assert property (
        ce && waiting_frame && q.ctrl[ATS_CTRL_FRM_EN] && line_edge && !cmd_stop
        |=> frame_start && (q.total == $past(q.total) + ATS_TOTAL_W'(1)))
        else $error("line edge did not start one frame");

    a_ignore_count : assert property (
        ce && !waiting_frame && q.ctrl[ATS_CTRL_FRM_EN] && line_edge && !wr_ign
        |=> !frame_start && (q.ignored == $past(q.ignored) + ATS_IGN_W'(1)))
        else $error("trigger outside frame wait not discarded");

    a_dir_gate : assert property (
        ce && q.ctrl[ATS_CTRL_DIR_OUT] && q.ctrl[ATS_CTRL_FRM_EN] |=> !frame_start)
        else $error("output line produced a trigger");

    a_auto_acq : assert property (
        ce && waiting_acq && !q.ctrl[ATS_CTRL_ACQ_EN] && !cmd_stop
        |=> waiting_frame)
        else $error("internal acquisition start missing");

    a_int_rate : assert property (
        // the previous mode is checked too: a line frame just before a switch keeps its tick
        ce && waiting_frame && !q.ctrl[ATS_CTRL_FRM_EN] && !cmd_stop && frame_start
        && !$past(q.ctrl[ATS_CTRL_FRM_EN]) |-> q.tick == '0)
        else $error("internal frame trigger off its period");

    a_edge_single : assert property (
        ce && line_rise |=> !line_rise)
        else $error("edge pulse longer than one cycle");

    c_burst_done : cover property (
        waiting_frame && frame_trig && (burst_nxt >= q.fcount) && ce ##1 waiting_acq);
    c_sw_trigger : cover property (waiting_acq && cmd_trig && ce);
    c_ignored    : cover property (!waiting_frame && line_edge && ce);
    c_stop       : cover property (waiting_frame && cmd_stop && ce);

endmodule

/* File: test/ats_line_src.sv */
// behavioural trigger source standing on general-purpose line 1
// assumes the bench raises fire once for every frame trigger it wants

`timescale 1ns/1ps

// ============================================================
// trigger source
module ats_line_src
#(
    parameter int HIGH_NS = 100
)
(
    input  wire logic fire,
    output logic      line
);
    initial line = 1'b0;

    // one clean rising edge per request, set off the clock grid on purpose
    // so the synchroniser sees a truly asynchronous change
    always @(posedge fire)
    begin
        #7 line = 1'b1;
        #(HIGH_NS) line = 1'b0;
    end
endmodule

/* File: test/test_acquisition_trigger_sequencer.sv */
// self-checking bench for the acquisition trigger sequencer
// assumes ats_pkg and ats_line_src are compiled first; ce drops only in t_freeze

`timescale 1ns/1ps

// ============================================================
// bench top
module test_acquisition_trigger_sequencer;
    import ats_pkg::*;

    logic              sys_clk   = 1'b0;
    logic              rst_n     = 1'b0;
    logic [ATS_AW-1:0] reg_addr  = 8'h00;
    logic [ATS_DW-1:0] reg_wdata = 32'h0;
    logic              reg_wr    = 1'b0;
    logic              reg_rd    = 1'b0;
    logic [ATS_DW-1:0] reg_rdata;
    logic              line1_out;
    logic              line1_oe;
    logic              frame_start;
    logic              waiting_acq;
    logic              waiting_frame;
    logic              src_line;
    logic              fire      = 1'b0;
    logic              ce        = 1'b1;
    wire               line_wire = line1_oe ? line1_out : src_line;
    int                err_total = 0;
    int                n_checks  = 0;
    int                n_fr      = 0;
    int                cyc       = 0;
    int                t_last    = 0;
    int                t_prev    = 0;

    // 25 ns clock
    always #12.5 sys_clk = ~sys_clk;

    ats_sequencer DUT
    (
        .sys_clk       (sys_clk),
        .rst_n         (rst_n),
        .ce            (ce),
        .reg_addr      (reg_addr),
        .reg_wdata     (reg_wdata),
        .reg_wr        (reg_wr),
        .reg_rd        (reg_rd),
        .reg_rdata     (reg_rdata),
        .line1_in      (line_wire),
        .line1_out     (line1_out),
        .line1_oe      (line1_oe),
        .frame_start   (frame_start),
        .waiting_acq   (waiting_acq),
        .waiting_frame (waiting_frame)
    );

    ats_line_src SRC
    (
        .fire (fire),
        .line (src_line)
    );

    // ============================================================
    // monitors: frame pulses are counted mid-cycle, after edge updates land
    always @(posedge sys_clk)
        cyc <= cyc + 1;

    always @(negedge sys_clk)
    begin
        if (frame_start === 1'b1)
        begin
            n_fr   = n_fr + 1;
            t_prev = t_last;
            t_last = cyc;
        end
    end

    // ============================================================
    // shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // a gap cycle after each strobe keeps one assignment per time step
    task automatic wr(input logic [ATS_AW-1:0] a, input logic [ATS_DW-1:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rd_chk(input logic [ATS_AW-1:0] a, input logic [ATS_DW-1:0] exp);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        @(negedge sys_clk);
        chk(reg_rdata, exp);
        @(posedge sys_clk);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // one pin edge, then enough time for sync latency and the frame pulse
    task automatic line_edge();
        fire <= 1'b1;
        idle(10);
        fire <= 1'b0;
        idle(1);
    endtask

    task automatic wait_frames(input int k);
        int n0;
        n0 = n_fr;
        for (int i = 0; i < 500 && n_fr < n0 + k; i++)
            @(posedge sys_clk);
        chk({31'h0, n_fr >= n0 + k}, 32'h1);
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ============================================================
    // scenarios
    task automatic t_reset();
        rd_chk(ATS_ADDR_CTRL, 32'h0);
        rd_chk(ATS_ADDR_FCOUNT, 32'h1);
        rd_chk(ATS_ADDR_PERIOD, 32'hFA0);
        rd_chk(8'h1C, 32'h0);
        chk({31'h0, waiting_frame}, 32'h0);
    endtask

    // software acquisition start, three line triggers, one stray edge before and one after
    task automatic t_burst();
        int n0;
        wr(ATS_ADDR_CTRL, 32'h3);
        wr(ATS_ADDR_FCOUNT, 32'h3);
        wr(ATS_ADDR_CMD, 32'h1);
        n0 = n_fr;
        chk({31'h0, waiting_acq}, 32'h1);
        line_edge();
        chk(n_fr - n0, 32'h0);
        wr(ATS_ADDR_CMD, 32'h4);
        chk({31'h0, waiting_frame}, 32'h1);
        for (int i = 1; i <= 3; i++)
        begin
            line_edge();
            chk(n_fr - n0, i);
        end
        chk({31'h0, waiting_acq}, 32'h1);
        rd_chk(ATS_ADDR_STATUS, 32'h0003_0002);
        rd_chk(ATS_ADDR_TOTAL, 32'h3);
        line_edge();
        chk(n_fr - n0, 32'h3);
        rd_chk(ATS_ADDR_IGNORED, 32'h2);
        // host re-arms with a fresh command, then stops the run
        wr(ATS_ADDR_CMD, 32'h4);
        chk({31'h0, waiting_frame}, 32'h1);
        wr(ATS_ADDR_CMD, 32'h2);
    endtask

    // line turned to output: its own edges must not trigger frames
    task automatic t_line_out();
        int n0;
        wr(ATS_ADDR_CTRL, 32'h0A);
        wr(ATS_ADDR_CMD, 32'h1);
        idle(2);
        n0 = n_fr;
        chk({31'h0, waiting_frame}, 32'h1);
        chk({31'h0, line1_oe}, 32'h1);
        wr(ATS_ADDR_CTRL, 32'h1A);
        chk({31'h0, line1_out}, 32'h1);
        idle(10);
        chk(n_fr - n0, 32'h0);
        wr(ATS_ADDR_CTRL, 32'h02);
        idle(6);
        line_edge();
        chk(n_fr - n0, 32'h1);
        wr(ATS_ADDR_CMD, 32'h2);
    endtask

    // internal frame triggers: default rate, programmed rate, clamped rate
    task automatic t_internal();
        wr(ATS_ADDR_FCOUNT, 32'hFFFF);
        wr(ATS_ADDR_CTRL, 32'h0);
        wr(ATS_ADDR_CMD, 32'h1);
        wait_frames(2);
        chk({31'h0, (t_last - t_prev) inside {[40:41]}}, 32'h1);
        wr(ATS_ADDR_PERIOD, 32'd100);
        wr(ATS_ADDR_CTRL, 32'h20);
        wait_frames(3);
        chk({31'h0, (t_last - t_prev) inside {[100:101]}}, 32'h1);
        wr(ATS_ADDR_PERIOD, 32'd10);
        wait_frames(3);
        chk({31'h0, (t_last - t_prev) inside {[40:41]}}, 32'h1);
        wr(ATS_ADDR_CMD, 32'h2);
        chk({31'h0, waiting_frame}, 32'h0);
    endtask

    // clock enable low: the frame timer stands still, then resumes
    task automatic t_freeze();
        int n0;
        wr(ATS_ADDR_CMD, 32'h1);
        wait_frames(1);
        n0 = n_fr;
        ce <= 1'b0;
        idle(100);
        chk(n_fr - n0, 32'h0);
        chk({31'h0, waiting_frame}, 32'h1);
        ce <= 1'b1;
        wait_frames(1);
        wr(ATS_ADDR_CMD, 32'h2);
    endtask

    // ============================================================
    // main sequence and watchdog
    initial
    begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        t_reset();
        t_burst();
        t_line_out();
        t_internal();
        t_freeze();
        close_out();
    end

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        close_out();
    end
endmodule
